// ---- zpq_defines.svh ----
// Constants for the zone pulse qualifier: timing counts, codes and limits
`ifndef ZPQ_DEFINES_SVH
`define ZPQ_DEFINES_SVH

// ****************************************
// Clock and time units
// ****************************************
`define ZPQ_CLK_PERIOD_NS   4
`define ZPQ_FINE_UNIT_MS    15
`define ZPQ_SECOND_MS       1000
`define ZPQ_MINUTE_S        60
`define ZPQ_NS_PER_MS       1000000
`define ZPQ_CYC_FINE        ((`ZPQ_FINE_UNIT_MS * `ZPQ_NS_PER_MS) / `ZPQ_CLK_PERIOD_NS)
`define ZPQ_CYC_SECOND      ((`ZPQ_SECOND_MS * `ZPQ_NS_PER_MS) / `ZPQ_CLK_PERIOD_NS)

// ****************************************
// Alarm cycles
// ****************************************
`define ZPQ_CYCLES_MIN      4'h1
`define ZPQ_CYCLES_REPEAT   4'hF

// ****************************************
// Loop codes from the terminal comparator
// ****************************************
`define ZPQ_LOOP_SHORT      3'h0
`define ZPQ_LOOP_ONE_R      3'h1
`define ZPQ_LOOP_TWO_R      3'h2
`define ZPQ_LOOP_OPEN       3'h7
`define ZPQ_EOL_OFFSET      3'h1

// ****************************************
// Reset values
// ****************************************
`define ZPQ_RST_COUNT       4'h0

`endif

// ---- zpq_pkg.sv ----
// Types for the zone pulse qualifier
package zpq_pkg;

	typedef enum logic [2:0] {BAL_NORM_OPEN, BAL_NORM_CLOSED, BAL_SINGLE, BAL_DOUBLE,
		BAL_SPLIT, BAL_SPLIT_EOL} zpq_bal_t;
	typedef enum logic [1:0] {DET_GENERIC, DET_ROLLER, DET_SHOCK} zpq_det_t;
	typedef enum logic [1:0] {LOC_MAIN, LOC_EXPANSION, LOC_KEYPAD} zpq_loc_t;
	typedef enum logic [2:0] {first_terminal, second_terminal, third_terminal,
		fourth_terminal, fifth_terminal, sixth_terminal, seventh_terminal,
		eighth_terminal} zpq_term_t;
	typedef enum logic {UNIT_FINE, UNIT_MINUTE} zpq_unit_t;

	typedef struct packed {
		zpq_bal_t  balancing;
		zpq_det_t  detector;
		zpq_loc_t  location;
		zpq_term_t terminal;
		logic [3:0] cycles;
		logic [7:0] pulse_qualify_time;
		zpq_unit_t qualify_unit;
		logic [7:0] window_time;
		zpq_unit_t window_unit;
		logic [3:0] pulses;
		logic [5:0] shock_sens;
	} zpq_cfg_t;

endpackage : zpq_pkg

// ---- zpq_timebase.sv ----
// Free-running tick generator: 15 ms, one second and one minute enables
`timescale 1ns/1ps
`include "zpq_defines.svh"

module zpq_timebase
	import zpq_pkg::*;
#(
	parameter int unsigned FINE_CYC   = `ZPQ_CYC_FINE,
	parameter int unsigned SECOND_CYC = `ZPQ_CYC_SECOND
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Tick enables
	output logic      tick_fine,
	output logic      tick_second,
	output logic      tick_minute
);

	// ****************************************
	// Counters
	// ****************************************
	logic [31:0] fine_cnt_ff, nxt_fine_cnt;
	logic [31:0] sec_cnt_ff,  nxt_sec_cnt;
	logic [5:0]  min_cnt_ff,  nxt_min_cnt;
	logic        tick_fine_ff, nxt_tick_fine;
	logic        tick_second_ff, nxt_tick_second;
	logic        tick_minute_ff, nxt_tick_minute;

	always_comb
	begin
		nxt_fine_cnt    = fine_cnt_ff + 32'h0000_0001;
		nxt_sec_cnt     = sec_cnt_ff + 32'h0000_0001;
		nxt_min_cnt     = min_cnt_ff;
		nxt_tick_fine   = 1'b0;
		nxt_tick_second = 1'b0;
		nxt_tick_minute = 1'b0;
		if (fine_cnt_ff >= FINE_CYC - 1)
		begin
			nxt_fine_cnt  = 32'h0000_0000;
			nxt_tick_fine = 1'b1;
		end
		if (sec_cnt_ff >= SECOND_CYC - 1)
		begin
			nxt_sec_cnt     = 32'h0000_0000;
			nxt_tick_second = 1'b1;
			nxt_min_cnt     = min_cnt_ff + 6'h01;
			if (min_cnt_ff == 6'(`ZPQ_MINUTE_S - 1))
			begin
				nxt_min_cnt     = 6'h00;
				nxt_tick_minute = 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			fine_cnt_ff    <= 32'h0000_0000;
			sec_cnt_ff     <= 32'h0000_0000;
			min_cnt_ff     <= 6'h00;
			tick_fine_ff   <= 1'b0;
			tick_second_ff <= 1'b0;
			tick_minute_ff <= 1'b0;
		end
		else
		begin
			fine_cnt_ff    <= nxt_fine_cnt;
			sec_cnt_ff     <= nxt_sec_cnt;
			min_cnt_ff     <= nxt_min_cnt;
			tick_fine_ff   <= nxt_tick_fine;
			tick_second_ff <= nxt_tick_second;
			tick_minute_ff <= nxt_tick_minute;
		end
	end

	assign tick_fine   = tick_fine_ff;
	assign tick_second = tick_second_ff;
	assign tick_minute = tick_minute_ff;

endmodule : zpq_timebase

// ---- zpq_zone.sv ----
// Zone pulse qualifier: balancing decode, pulse timing, window counting, alarm cycles
`timescale 1ns/1ps
`include "zpq_defines.svh"

// How it works
// - The loop code is decoded for normally open, normally closed, single, double and both split-zone balancings.
// - The alarm-cycle limit is taken as 1 to 15, a zero being raised to 1, and alarms stop once a limit of 1 to 14 is used.
// - A limit of 15 makes the zone repetitive with no cap on alarm cycles.
// - A generic condition must persist for the qualify time, in 15 ms units or minutes, to count as a pulse.
// - A generic zone needing more than one pulse alarms only when that many arrive inside its window.
// - A generic zone raises its alarm event once the set number of qualified pulses is seen.
// - A rollerblind zone needing more than one pulse alarms only after that many inside its window.
// - A higher shock sensitivity value demands a stronger shock, so detection gets less sensitive.
// - A shock zone needing more than one pulse alarms only when that many arrive inside its window.
// - A shock zone with a pulse count of 0 alarms on the sensitivity comparison alone, counting nothing.
// - Minute intervals run on a free minute tick, so they end up to one minute early but never late.
module zpq_zone
	import zpq_pkg::*;
#(
	parameter int unsigned FINE_CYC   = `ZPQ_CYC_FINE,
	parameter int unsigned SECOND_CYC = `ZPQ_CYC_SECOND
)
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// Configuration
	input  wire zpq_cfg_t   cfg,
	input  wire logic       cycles_clear,
	// Detector side
	input  wire logic [2:0] loop_code,
	input  wire logic [5:0] shock_level,
	// Results
	output logic            zone_alarm,
	output logic            second_alarm,
	output logic            loop_tamper,
	output logic            config_error,
	output logic [3:0]      pulse_count,
	output logic [3:0]      cycles_used
);

	// ****************************************
	// Time base
	// ****************************************
	logic tick_fine, tick_second, tick_minute;

	zpq_timebase #(
		.FINE_CYC   (FINE_CYC),
		.SECOND_CYC (SECOND_CYC)
	) u_timebase (
		.clk         (clk),
		.reset       (reset),
		.tick_fine   (tick_fine),
		.tick_second (tick_second),
		.tick_minute (tick_minute)
	);

	// ****************************************
	// Balancing decode and type check
	// ****************************************
	logic       cond_a, cond_b, tamper, type_ok;
	logic [2:0] split_code;

	always_comb
	begin
		cond_a     = 1'b0;
		cond_b     = 1'b0;
		tamper     = 1'b0;
		split_code = loop_code;
		unique case (cfg.balancing)
			BAL_NORM_OPEN:   cond_a = (loop_code == `ZPQ_LOOP_SHORT);
			BAL_NORM_CLOSED: cond_a = (loop_code != `ZPQ_LOOP_SHORT);
			BAL_SINGLE:
			begin
				cond_a = (loop_code != `ZPQ_LOOP_ONE_R);
				tamper = (loop_code == `ZPQ_LOOP_SHORT);
			end
			BAL_DOUBLE:
			begin
				cond_a = (loop_code == `ZPQ_LOOP_TWO_R);
				tamper = (loop_code != `ZPQ_LOOP_ONE_R) && !cond_a;
			end
			BAL_SPLIT, BAL_SPLIT_EOL:
			begin
				if (cfg.balancing == BAL_SPLIT_EOL)
					split_code = loop_code - `ZPQ_EOL_OFFSET;
				tamper = (loop_code == `ZPQ_LOOP_OPEN) ||
					(cfg.balancing == BAL_SPLIT_EOL && loop_code == `ZPQ_LOOP_SHORT);
				cond_a = split_code[0] && !tamper;
				cond_b = split_code[1] && !tamper;
			end
			default: tamper = 1'b1;
		endcase
		type_ok = (cfg.detector == DET_GENERIC) || (cfg.location == LOC_KEYPAD) ||
			(cfg.location == LOC_MAIN && cfg.terminal <= second_terminal) ||
			(cfg.location == LOC_EXPANSION && cfg.terminal <= fourth_terminal);
	end

	// ****************************************
	// Pulse sources
	// ****************************************
	logic       shock_over;
	logic       prev_a_ff, prev_b_ff, prev_over_ff;
	logic       qual_done_ff, nxt_qual_done;
	logic [7:0] qual_cnt_ff, nxt_qual_cnt;
	logic       qual_evt, pulse_evt, qual_tick;
	logic [7:0] qual_target;

	always_comb
	begin
		shock_over    = (shock_level > cfg.shock_sens);
		qual_tick     = (cfg.qualify_unit == UNIT_MINUTE) ? tick_minute : tick_fine;
		qual_target   = (cfg.pulse_qualify_time == 8'h00) ? 8'h01 : cfg.pulse_qualify_time;
		nxt_qual_cnt  = qual_cnt_ff;
		nxt_qual_done = qual_done_ff;
		qual_evt      = 1'b0;
		if (!cond_a)
		begin
			nxt_qual_cnt  = 8'h00;
			nxt_qual_done = 1'b0;
		end
		else if (!qual_done_ff && qual_tick)
		begin
			nxt_qual_cnt = qual_cnt_ff + 8'h01;
			if (nxt_qual_cnt >= qual_target)
			begin
				qual_evt      = 1'b1;
				nxt_qual_done = 1'b1;
			end
		end
		unique case (cfg.detector)
			DET_GENERIC: pulse_evt = qual_evt;
			DET_ROLLER:  pulse_evt = cond_a && !prev_a_ff;
			DET_SHOCK:   pulse_evt = shock_over && !prev_over_ff;
			default:     pulse_evt = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			prev_a_ff    <= 1'b0;
			prev_b_ff    <= 1'b0;
			prev_over_ff <= 1'b0;
			qual_cnt_ff  <= 8'h00;
			qual_done_ff <= 1'b0;
		end
		else
		begin
			prev_a_ff    <= cond_a;
			prev_b_ff    <= cond_b;
			prev_over_ff <= shock_over;
			qual_cnt_ff  <= nxt_qual_cnt;
			qual_done_ff <= nxt_qual_done;
		end
	end

	// ****************************************
	// Window counting and alarm cycles
	// ****************************************
	typedef enum logic {ST_IDLE, ST_COUNT} zpq_state_t;
	zpq_state_t state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] win_cnt_ff, nxt_win_cnt;
	logic [3:0] used_ff, nxt_used;
	logic       alarm_ff, nxt_alarm;
	logic       second_ff, nxt_second;
	logic       tamper_ff, cfg_err_ff;
	logic [3:0] need, lim_eff;
	logic [7:0] win_target;
	logic       win_tick, win_expire, cycle_ok, alarm_req;

	always_comb
	begin
		need       = (cfg.pulses == 4'h0) ? 4'h1 : cfg.pulses;
		lim_eff    = (cfg.cycles < `ZPQ_CYCLES_MIN) ? `ZPQ_CYCLES_MIN : cfg.cycles;
		cycle_ok   = (lim_eff == `ZPQ_CYCLES_REPEAT) || (used_ff < lim_eff);
		win_target = (cfg.window_time == 8'h00) ? 8'h01 : cfg.window_time;
		win_tick   = (cfg.window_unit == UNIT_MINUTE) ? tick_minute : tick_second;
		win_expire = win_tick && (win_cnt_ff + 8'h01 >= win_target);
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_win_cnt = win_cnt_ff;
		alarm_req  = 1'b0;
		unique case (state_ff)
			ST_IDLE:
			begin
				if (pulse_evt && need == 4'h1)
					alarm_req = 1'b1;
				else if (pulse_evt && cfg.detector == DET_SHOCK && cfg.pulses == 4'h0)
					alarm_req = 1'b1;
				else if (pulse_evt)
				begin
					nxt_state   = ST_COUNT;
					nxt_cnt     = 4'h1;
					nxt_win_cnt = 8'h00;
				end
			end
			ST_COUNT:
			begin
				if (pulse_evt && cnt_ff + 4'h1 >= need)
				begin
					alarm_req = 1'b1;
					nxt_state = ST_IDLE;
					nxt_cnt   = `ZPQ_RST_COUNT;
				end
				else if (win_expire)
				begin
					nxt_state = ST_IDLE;
					nxt_cnt   = `ZPQ_RST_COUNT;
				end
				else
				begin
					if (pulse_evt)
						nxt_cnt = cnt_ff + 4'h1;
					if (win_tick)
						nxt_win_cnt = win_cnt_ff + 8'h01;
				end
			end
		endcase
		nxt_alarm  = alarm_req && type_ok && cycle_ok;
		nxt_second = cond_b && !prev_b_ff && type_ok && cycle_ok;
		nxt_used   = used_ff;
		if (cycles_clear)
			nxt_used = `ZPQ_RST_COUNT;
		else if ((nxt_alarm || nxt_second) && used_ff != `ZPQ_CYCLES_REPEAT)
			nxt_used = used_ff + 4'h1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_ff   <= ST_IDLE;
			cnt_ff     <= `ZPQ_RST_COUNT;
			win_cnt_ff <= 8'h00;
			used_ff    <= `ZPQ_RST_COUNT;
			alarm_ff   <= 1'b0;
			second_ff  <= 1'b0;
			tamper_ff  <= 1'b0;
			cfg_err_ff <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			win_cnt_ff <= nxt_win_cnt;
			used_ff    <= nxt_used;
			alarm_ff   <= nxt_alarm;
			second_ff  <= nxt_second;
			tamper_ff  <= tamper;
			cfg_err_ff <= !type_ok;
		end
	end

	assign zone_alarm   = alarm_ff;
	assign second_alarm = second_ff;
	assign loop_tamper  = tamper_ff;
	assign config_error = cfg_err_ff;
	assign pulse_count  = cnt_ff;
	assign cycles_used  = used_ff;

	// ****************************************
	// Assertions
	// ****************************************
	AST_TYPE_BLOCK: assert property (@(posedge clk) disable iff (reset)
		!type_ok |=> !alarm_ff && cfg_err_ff)
		else $error("Alarm raised on a terminal that rejects the type");
	AST_CYCLE_CAP: assert property (@(posedge clk) disable iff (reset)
		alarm_ff && $past(lim_eff) != 4'hF && !$past(cycles_clear) |-> used_ff <= $past(lim_eff))
		else $error("Alarm cycles exceeded the limit");
	AST_REPEAT: assert property (@(posedge clk) disable iff (reset)
		cfg.cycles == 4'hF && alarm_req && type_ok |=> alarm_ff)
		else $error("Repetitive zone suppressed an alarm");
	AST_WIN_CLEAR: assert property (@(posedge clk) disable iff (reset)
		state_ff == ST_COUNT && win_expire && !pulse_evt |=> cnt_ff == 4'h0 && state_ff == ST_IDLE)
		else $error("Window expiry did not clear the count");
	AST_SHOCK_DIRECT: assert property (@(posedge clk) disable iff (reset)
		cfg.detector == DET_SHOCK && cfg.pulses == 4'h0 && shock_over && !prev_over_ff &&
		state_ff == ST_IDLE && type_ok && cycle_ok |=> alarm_ff)
		else $error("Shock comparison did not raise the alarm");
	AST_ALARM_CAUSE: assert property (@(posedge clk) disable iff (reset)
		alarm_ff |-> $past(pulse_evt) && ($past(cnt_ff) + 4'h1 >= $past(need) ||
		$past(state_ff) == ST_IDLE))
		else $error("Alarm without the required pulse count");
	AST_QUALIFY: assert property (@(posedge clk) disable iff (reset)
		cfg.detector == DET_GENERIC && cfg.qualify_unit == UNIT_FINE &&
		cfg.pulse_qualify_time == 8'h03
		&& $rose(cond_a) ##1 (cond_a && !tick_fine)[*2] |-> !qual_done_ff || $past(qual_done_ff, 2))
		else $error("Generic pulse qualified too early");
	AST_SPLIT_B: assert property (@(posedge clk) disable iff (reset)
		cfg.balancing == BAL_SPLIT && loop_code == 3'h2 && !prev_b_ff && type_ok && cycle_ok
		|=> second_ff)
		else $error("Split zone second contact missed");

endmodule : zpq_zone

// ---- zpq_detector_model.sv ----
// Detector model: turns alarm, tamper and shock requests into terminal levels
`timescale 1ns/1ps
module zpq_detector_model
	import zpq_pkg::*;
(
	// Requests from the bench
	input  wire zpq_bal_t   bal,
	input  wire logic       hit,
	input  wire logic       hit_b,
	input  wire logic       tamper,
	input  wire logic [5:0] level,
	// Zone terminal
	output logic [2:0]      loop_code,
	output logic [5:0]      shock_level
);
	// ****************************************
	// Loop resistance per balancing
	// ****************************************
	always_comb
	begin
		case (bal)
			BAL_NORM_OPEN:   loop_code = hit ? 3'h0 : 3'h7;
			BAL_NORM_CLOSED: loop_code = hit ? 3'h7 : 3'h0;
			BAL_SINGLE:      loop_code = tamper ? 3'h0 : (hit ? 3'h7 : 3'h1);
			BAL_DOUBLE:      loop_code = tamper ? 3'h0 : (hit ? 3'h2 : 3'h1);
			BAL_SPLIT:       loop_code = tamper ? 3'h7 : {1'b0, hit_b, hit};
			default:         loop_code = tamper ? 3'h7 : {1'b0, hit_b, hit} + 3'h1;
		endcase
		shock_level = level;
	end
endmodule : zpq_detector_model

// ---- zone_pulse_qualifier_tb_top.sv ----
// Testbench for the zone pulse qualifier
`timescale 1ns/1ps
module zone_pulse_qualifier_tb_top;
	import zpq_pkg::*;
	logic        clk, reset, cycles_clear, hit, hit_b, tamper;
	logic [5:0]  level, shock_level;
	logic [2:0]  loop_code;
	zpq_cfg_t    cfg;
	logic        zone_alarm, second_alarm, loop_tamper, config_error;
	logic [3:0]  pulse_count, cycles_used;
	int          bad_count, checked, alarms, a0, seconds, b0;
	logic [31:0] seed;
	logic [5:0]  sens;
	zpq_loc_t    locs[6]  = '{LOC_MAIN, LOC_MAIN, LOC_EXPANSION, LOC_EXPANSION, LOC_KEYPAD, LOC_MAIN};
	zpq_term_t   terms[6] = '{third_terminal, second_terminal, fourth_terminal, fifth_terminal,
		eighth_terminal, eighth_terminal};
	zpq_det_t    dets[6]  = '{DET_ROLLER, DET_SHOCK, DET_ROLLER, DET_SHOCK, DET_SHOCK, DET_GENERIC};
	logic [7:0]  errs[6]  = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

	zpq_zone #(.FINE_CYC(10), .SECOND_CYC(40)) u_dut (.clk(clk), .reset(reset), .cfg(cfg),
		.cycles_clear(cycles_clear), .loop_code(loop_code), .shock_level(shock_level),
		.zone_alarm(zone_alarm), .second_alarm(second_alarm), .loop_tamper(loop_tamper),
		.config_error(config_error), .pulse_count(pulse_count), .cycles_used(cycles_used));
	zpq_detector_model u_det (.bal(cfg.balancing), .hit(hit), .hit_b(hit_b), .tamper(tamper),
		.level(level),
		.loop_code(loop_code), .shock_level(shock_level));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (reset)
		begin
			alarms  <= 0;
			seconds <= 0;
		end
		else
		begin
			if (zone_alarm === 1'b1)
				alarms <= alarms + 1;
			if (second_alarm === 1'b1)
				seconds <= seconds + 1;
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk

	task automatic setup(zpq_det_t d, logic [3:0] p, logic [3:0] cyc);
		cfg.detector = d;
		cfg.pulses = p;
		cfg.cycles = cyc;
		cycles_clear = 1'b1;
		@(negedge clk);
		cycles_clear = 1'b0;
		repeat (5) @(negedge clk);
		a0 = alarms;
		b0 = seconds;
	endtask : setup

	task automatic pulse(int len, int gap);
		hit = 1'b1;
		repeat (len) @(negedge clk);
		hit = 1'b0;
		repeat (gap) @(negedge clk);
	endtask : pulse

	task automatic complete_run();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	initial
	begin
		#100000;
		bad_count++;
		complete_run();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{cycles_clear, hit, hit_b, tamper, level, bad_count, checked} = '0;
		seed = 32'h3b9b_4e3f;
		cfg = '0;
		cfg.window_time = 8'h04;
		cfg.pulse_qualify_time = 8'h03;
		reset = 1'b1;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		chk("idle", {zone_alarm, loop_tamper, config_error, pulse_count, cycles_used[0]}, 8'h00);
		for (int b = 0; b < 6; b++)
		begin
			cfg.balancing = zpq_bal_t'(b);
			setup(DET_ROLLER, 4'h1, 4'hF);
			pulse(3, 5);
			chk("bal_alarm", 8'(alarms - a0), 8'h01);
		end
		for (int b = 4; b < 6; b++)
		begin
			cfg.balancing = zpq_bal_t'(b);
			setup(DET_ROLLER, 4'h1, 4'hF);
			hit_b = 1'b1;
			repeat (3) @(negedge clk);
			hit_b = 1'b0;
			repeat (3) @(negedge clk);
			chk("split_second", 8'(seconds - b0), 8'h01);
			chk("split_main", 8'(alarms - a0), 8'h00);
			chk("split_used", {4'h0, cycles_used}, 8'h01);
		end
		cfg.balancing = BAL_SINGLE;
		tamper = 1'b1;
		repeat (3) @(negedge clk);
		chk("tamper", {7'h00, loop_tamper}, 8'h01);
		tamper = 1'b0;
		setup(DET_ROLLER, 4'h2, 4'hF);
		pulse(3, 10);
		chk("roll_cnt", {4'h0, pulse_count}, 8'h01);
		pulse(3, 5);
		chk("roll_alarm", 8'(alarms - a0), 8'h01);
		pulse(3, 220);
		chk("roll_expire", {4'h0, pulse_count}, 8'h00);
		chk("roll_quiet", 8'(alarms - a0), 8'h01);
		cfg.window_unit = UNIT_MINUTE;
		cfg.window_time = 8'h02;
		pulse(3, 2200);
		pulse(3, 5);
		chk("min_alarm", 8'(alarms - a0), 8'h02);
		pulse(3, 4900);
		chk("min_expire", {4'h0, pulse_count}, 8'h00);
		cfg.window_unit = UNIT_FINE;
		cfg.window_time = 8'h04;
		setup(DET_SHOCK, 4'h0, 4'hF);
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr_next(seed);
			sens = (i == 0) ? 6'h00 : seed[5:0] % 6'h3F;
			cfg.shock_sens = sens;
			a0 = alarms;
			level = sens;
			repeat (4) @(negedge clk);
			level = 6'h00;
			repeat (3) @(negedge clk);
			chk("shock_equal", 8'(alarms - a0), 8'h00);
			level = sens + 6'h01 + 6'(seed[9:6] % (6'h3E - sens + 6'h01));
			repeat (3) @(negedge clk);
			level = 6'h00;
			repeat (3) @(negedge clk);
			chk("shock_above", 8'(alarms - a0), 8'h01);
		end
		setup(DET_SHOCK, 4'h3, 4'hF);
		for (int i = 0; i < 3; i++)
		begin
			level = 6'h3F;
			repeat (3) @(negedge clk);
			level = 6'h00;
			repeat (4) @(negedge clk);
			if (i == 1)
				chk("shock_cnt", {4'h0, pulse_count}, 8'h02);
		end
		chk("shock_alarm", 8'(alarms - a0), 8'h01);
		setup(DET_GENERIC, 4'h1, 4'hF);
		pulse(15, 5);
		chk("gen_short", 8'(alarms - a0), 8'h00);
		pulse(40, 5);
		chk("gen_long", 8'(alarms - a0), 8'h01);
		setup(DET_GENERIC, 4'h2, 4'hF);
		pulse(40, 5);
		chk("gen_cnt", {4'h0, pulse_count}, 8'h01);
		pulse(40, 5);
		chk("gen_alarm", 8'(alarms - a0), 8'h01);
		setup(DET_GENERIC, 4'h1, 4'hF);
		cfg.qualify_unit = UNIT_MINUTE;
		cfg.pulse_qualify_time = 8'h01;
		pulse(2450, 5);
		chk("gen_minute", 8'(alarms - a0), 8'h01);
		cfg.qualify_unit = UNIT_FINE;
		cfg.pulse_qualify_time = 8'h03;
		for (int k = 0; k < 6; k++)
		begin
			cfg.location = locs[k];
			cfg.terminal = terms[k];
			setup(dets[k], 4'h0, 4'hF);
			level = 6'h3F;
			pulse(30, 5);
			level = 6'h00;
			chk("cfg_err", {7'h00, config_error}, errs[k]);
			chk("cfg_refuse", 8'(alarms - a0), errs[k] ^ 8'h01);
		end
		cfg.location = LOC_MAIN;
		cfg.terminal = first_terminal;
		setup(DET_ROLLER, 4'h1, 4'h1);
		pulse(3, 5);
		pulse(3, 5);
		chk("cyc_limit", 8'(alarms - a0), 8'h01);
		chk("cyc_used", {4'h0, cycles_used}, 8'h01);
		setup(DET_ROLLER, 4'h1, 4'hF);
		chk("cyc_clear", {4'h0, cycles_used}, 8'h00);
		repeat (17) pulse(3, 5);
		chk("cyc_repeat", 8'(alarms - a0), 8'h11);
		chk("cyc_sat", {4'h0, cycles_used}, 8'h0F);
		complete_run();
	end
endmodule : zone_pulse_qualifier_tb_top
